// File: inc/modem_phy_state_pkg.sv
// Package for the modem state monitor: register map, field layout,
// reset values and the state codes of both state machines.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package modem_phy_state_pkg;

	localparam int        DATA_W         = 32;
	localparam int        TX_W           = 4;
	localparam int        RX_W           = 3;

	// Register byte offsets
	localparam logic [7:0] CTRL0_OFFS    = 8'h00;
	localparam logic [7:0] CTRL1_OFFS    = 8'h04;

	// Control0 layout
	localparam int        RX_FORCE_BIT   = 7;
	localparam int        RX_CODE_LSB    = 4;
	localparam int        TX_CODE_LSB    = 0;
	// Control1 layout
	localparam int        TX_FORCE_BIT   = 7;

	// Reset values
	localparam logic       FORCE_N_RST   = 1'b1;
	localparam logic [3:0] TX_CODE_RST   = 4'h0;
	localparam logic [2:0] RX_CODE_RST   = 3'h0;

	typedef enum logic [3:0] {
		tx_idle             = 4'h0,
		tx_fifo_wait_first  = 4'h1,
		tx_fifo_wait_second = 4'h2,
		tx_length_check     = 4'h3,
		tx_preamble_send    = 4'h4,
		tx_delimiter_send   = 4'h5,
		tx_length_send      = 4'h7,
		tx_body_send        = 4'h8,
		tx_tail_send        = 4'h9,
		tx_continuous_test  = 4'ha
	} tx_state_t;

	typedef enum logic [2:0] {
		rx_idle                 = 3'h0,
		rx_packet_wait          = 3'h1,
		rx_timing_wait          = 3'h2,
		rx_coarse_first         = 3'h3,
		rx_coarse_second        = 3'h4,
		rx_symbol_detect_first  = 3'h5,
		rx_symbol_detect_second = 3'h6,
		rx_packet_done          = 3'h7
	} rx_state_t;

	// Code 0110 and everything above 1010 are never entered
	function automatic logic tx_code_legal(input logic [3:0] code);
		tx_code_legal = (code <= 4'ha) && (code != 4'h6);
	endfunction

endpackage

// File: rtl/rx_demod_tracker.sv
// Demodulator state tracker with software override.
// Assumes event inputs come from logic on clk_i.
module rx_demod_tracker (
	input  wire logic                               clk_i,
	input  wire logic                               rst_n_i,
	input  wire logic                               force_n_i,
	input  wire logic [modem_phy_state_pkg::RX_W-1:0] req_code_i,
	input  wire logic                               rx_enable_i,
	input  wire logic                               rx_packet_detect_i,
	input  wire logic                               rx_timing_locked_i,
	input  wire logic                               rx_signal_ready_i,
	input  wire logic                               rx_stage_done_i,
	output modem_phy_state_pkg::rx_state_t          state_o
);
	import modem_phy_state_pkg::*;

	rx_state_t state_q;
	rx_state_t state_d;
	rx_state_t walk_d;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		walk_d = state_q;
		case (state_q)
			rx_idle:                 if (rx_enable_i) walk_d = rx_packet_wait;
			rx_packet_wait:          if (rx_packet_detect_i) walk_d = rx_timing_wait;
			rx_timing_wait:          if (rx_timing_locked_i) walk_d = rx_coarse_first;
			rx_coarse_first:         if (rx_signal_ready_i) walk_d = rx_coarse_second;
			rx_coarse_second:        if (rx_stage_done_i) walk_d = rx_symbol_detect_first;
			rx_symbol_detect_first:  if (rx_signal_ready_i) walk_d = rx_symbol_detect_second;
			rx_symbol_detect_second: if (rx_stage_done_i) walk_d = rx_packet_done;
			rx_packet_done:          walk_d = rx_packet_wait;
			default:                 walk_d = rx_idle;
		endcase
		if (!rx_enable_i)
			walk_d = rx_idle;
	end

	// Forcing pins the machine to the stored code
	assign state_d = force_n_i ? walk_d : rx_state_t'(req_code_i);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			state_q <= rx_idle;
		else
			state_q <= state_d;
	end

	assign state_o = state_q;

	////////////////////////////////////////////////////////////////////
	sequence s_symbol_walk;
		state_q == rx_symbol_detect_first && force_n_i && rx_enable_i && rx_signal_ready_i;
	endsequence

	property p_rx_symbol;
		@(posedge clk_i) disable iff (!rst_n_i)
		s_symbol_walk |=> state_q == rx_symbol_detect_second;
	endproperty
	a_rx_symbol: assert property (p_rx_symbol) else $error("rx symbol stage did not advance");

	property p_rx_done;
		@(posedge clk_i) disable iff (!rst_n_i)
		state_q == rx_symbol_detect_second && force_n_i && rx_enable_i && rx_stage_done_i
			|=> state_q == rx_packet_done;
	endproperty
	a_rx_done: assert property (p_rx_done) else $error("rx packet end not reported");

	property p_rx_force;
		@(posedge clk_i) disable iff (!rst_n_i)
		!force_n_i ##1 !force_n_i |-> state_q == $past(req_code_i);
	endproperty
	a_rx_force: assert property (p_rx_force) else $error("rx state not held at forced code");

endmodule

// File: rtl/modem_phy_state_monitor.sv
// Modem state monitor: Wishbone register bank over the transmit
// state machine and the receive state tracker.
// Assumes classic Wishbone from clk_i and same-clock event inputs.
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
module modem_phy_state_monitor #(
	parameter int ADDR_W = 8
) (
	input  wire logic                                 clk_i,
	input  wire logic                                 rst_n_i,
	input  wire logic                                 wb_cyc_i,
	input  wire logic                                 wb_stb_i,
	input  wire logic                                 wb_we_i,
	input  wire logic [ADDR_W-1:0]                    wb_adr_i,
	input  wire logic [3:0]                           wb_sel_i,
	input  wire logic [modem_phy_state_pkg::DATA_W-1:0] wb_dat_i,
	output logic      [modem_phy_state_pkg::DATA_W-1:0] wb_dat_o,
	output logic                                      wb_ack_o,
	input  wire logic                                 tx_request_i,
	input  wire logic                                 tx_fifo_ready_i,
	input  wire logic                                 tx_length_valid_i,
	input  wire logic                                 tx_section_done_i,
	input  wire logic                                 tx_test_mode_i,
	input  wire logic                                 rx_enable_i,
	input  wire logic                                 rx_packet_detect_i,
	input  wire logic                                 rx_timing_locked_i,
	input  wire logic                                 rx_signal_ready_i,
	input  wire logic                                 rx_stage_done_i,
	output modem_phy_state_pkg::tx_state_t            tx_state_o,
	output modem_phy_state_pkg::rx_state_t            rx_state_o
);
	import modem_phy_state_pkg::*;

	if (ADDR_W < 3 || ADDR_W > 8) begin : g_addr_check
		$error("ADDR_W must be 3 to 8");
	end

	////////////////////////////////////////////////////////////////////
	// Register state

	logic              ack_q;
	logic [DATA_W-1:0] dat_q;
	logic [DATA_W-1:0] dat_d;
	logic              rx_force_n_q;
	logic [RX_W-1:0]   rx_req_q;
	logic              tx_force_n_q;
	logic [TX_W-1:0]   tx_req_q;
	tx_state_t         tx_state_q;
	tx_state_t         tx_state_d;
	tx_state_t         tx_walk_d;
	rx_state_t         rx_state;

	////////////////////////////////////////////////////////////////////
	// Bus decode

	wire logic bus_req;
	wire logic hit0;
	wire logic hit1;
	wire logic wr_take;
	wire logic wr_ctrl0;
	wire logic wr_ctrl1;
	wire logic rd_start;

	assign bus_req  = wb_cyc_i & wb_stb_i;
	assign hit0     = wb_adr_i == CTRL0_OFFS[ADDR_W-1:0];
	assign hit1     = wb_adr_i == CTRL1_OFFS[ADDR_W-1:0];
	// Write lands on the edge the master samples ack
	assign wr_take  = bus_req & wb_we_i & ack_q & wb_sel_i[0];
	assign wr_ctrl0 = wr_take & hit0;
	assign wr_ctrl1 = wr_take & hit1;
	assign rd_start = bus_req & ~ack_q;

	// Reads show live machine states, never the stored request
	wire logic [DATA_W-1:0] ctrl0_view;
	wire logic [DATA_W-1:0] ctrl1_view;
	wire logic [DATA_W-1:0] rd_mux;

	assign ctrl0_view = {24'h00_0000, rx_force_n_q, rx_state, tx_state_q};
	assign ctrl1_view = {24'h00_0000, tx_force_n_q, 7'h00};
	assign rd_mux     = hit0 ? ctrl0_view :
	                    hit1 ? ctrl1_view : 32'h0000_0000;
	// Unmapped addresses still ack, with zero data
	assign dat_d      = rd_start ? rd_mux : dat_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= rd_start;
			dat_q <= dat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	////////////////////////////////////////////////////////////////////
	// Request and force registers

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_force_n_q <= FORCE_N_RST;
			rx_req_q     <= RX_CODE_RST;
			tx_req_q     <= TX_CODE_RST;
		end else if (wr_ctrl0) begin
			rx_force_n_q <= wb_dat_i[RX_FORCE_BIT];
			rx_req_q     <= wb_dat_i[RX_CODE_LSB +: RX_W];
			tx_req_q     <= wb_dat_i[TX_CODE_LSB +: TX_W];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			tx_force_n_q <= FORCE_N_RST;
		else if (wr_ctrl1)
			tx_force_n_q <= wb_dat_i[TX_FORCE_BIT];
	end

	////////////////////////////////////////////////////////////////////
	// Modulation state machine

	always_comb begin
		tx_walk_d = tx_state_q;
		case (tx_state_q)
			tx_idle: begin
				if (tx_request_i)
					tx_walk_d = tx_fifo_wait_first;
				else if (tx_test_mode_i)
					tx_walk_d = tx_continuous_test;
			end
			tx_fifo_wait_first:
				if (tx_fifo_ready_i) tx_walk_d = tx_fifo_wait_second;
			tx_fifo_wait_second:
				if (tx_fifo_ready_i) tx_walk_d = tx_length_check;
			tx_length_check:
				tx_walk_d = tx_length_valid_i ? tx_preamble_send : tx_idle;
			tx_preamble_send:
				if (tx_section_done_i) tx_walk_d = tx_delimiter_send;
			tx_delimiter_send:
				if (tx_section_done_i) tx_walk_d = tx_length_send;
			tx_length_send:
				if (tx_section_done_i) tx_walk_d = tx_body_send;
			tx_body_send:
				if (tx_section_done_i) tx_walk_d = tx_tail_send;
			tx_tail_send:
				if (tx_section_done_i) tx_walk_d = tx_idle;
			tx_continuous_test:
				if (!tx_test_mode_i) tx_walk_d = tx_idle;
			default:
				tx_walk_d = tx_idle;
		endcase
	end

	// Reserved request codes leave the forced state where it is
	assign tx_state_d = tx_force_n_q ? tx_walk_d :
	                    tx_code_legal(tx_req_q) ? tx_state_t'(tx_req_q) : tx_state_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			tx_state_q <= tx_idle;
		else
			tx_state_q <= tx_state_d;
	end

	assign tx_state_o = tx_state_q;

	////////////////////////////////////////////////////////////////////
	// Demodulation tracker

	rx_demod_tracker u_rx (
		.clk_i              (clk_i),
		.rst_n_i            (rst_n_i),
		.force_n_i          (rx_force_n_q),
		.req_code_i         (rx_req_q),
		.rx_enable_i        (rx_enable_i),
		.rx_packet_detect_i (rx_packet_detect_i),
		.rx_timing_locked_i (rx_timing_locked_i),
		.rx_signal_ready_i  (rx_signal_ready_i),
		.rx_stage_done_i    (rx_stage_done_i),
		.state_o            (rx_state)
	);

	assign rx_state_o = rx_state;

	////////////////////////////////////////////////////////////////////
	// Checks

	property p_tx_no_reserved;
		@(posedge clk_i) disable iff (!rst_n_i)
		tx_code_legal(tx_state_q);
	endproperty
	a_tx_no_reserved: assert property (p_tx_no_reserved) else $error("tx state in reserved code");

	property p_tx_write_only;
		@(posedge clk_i) disable iff (!rst_n_i)
		wr_ctrl0 && tx_force_n_q && tx_state_q == tx_idle && !tx_request_i && !tx_test_mode_i
			|=> tx_state_q == tx_idle;
	endproperty
	a_tx_write_only: assert property (p_tx_write_only) else $error("tx state moved on write");

	property p_tx_force;
		@(posedge clk_i) disable iff (!rst_n_i)
		!tx_force_n_q && tx_code_legal(tx_req_q) |=> tx_state_q == $past(tx_req_q);
	endproperty
	a_tx_force: assert property (p_tx_force) else $error("tx state not pinned to request");

	sequence s_fifo_waits;
		tx_state_q == tx_fifo_wait_first && tx_force_n_q && tx_fifo_ready_i
			##1 tx_force_n_q && tx_fifo_ready_i;
	endsequence

	property p_tx_waits;
		@(posedge clk_i) disable iff (!rst_n_i)
		s_fifo_waits |=> tx_state_q == tx_length_check;
	endproperty
	a_tx_waits: assert property (p_tx_waits) else $error("tx fifo waits out of order");

	property p_tx_check;
		@(posedge clk_i) disable iff (!rst_n_i)
		tx_state_q == tx_length_check && tx_force_n_q
			|=> tx_state_q == ($past(tx_length_valid_i) ? tx_preamble_send : tx_idle);
	endproperty
	a_tx_check: assert property (p_tx_check) else $error("tx length check wrong exit");

	sequence s_frame_head;
		tx_state_q == tx_preamble_send && tx_force_n_q && tx_section_done_i;
	endsequence

	property p_tx_head;
		@(posedge clk_i) disable iff (!rst_n_i)
		s_frame_head |=> tx_state_q == tx_delimiter_send;
	endproperty
	a_tx_head: assert property (p_tx_head) else $error("tx preamble did not lead to delimiter");

	sequence s_frame_tail;
		tx_state_q == tx_length_send && tx_force_n_q && tx_section_done_i
			##1 tx_force_n_q && tx_section_done_i
			##1 tx_force_n_q && tx_section_done_i;
	endsequence

	property p_tx_tail;
		@(posedge clk_i) disable iff (!rst_n_i)
		s_frame_tail |=> tx_state_q == tx_idle;
	endproperty
	a_tx_tail: assert property (p_tx_tail) else $error("tx length body tail order broken");

	property p_tx_continuous_test;
		@(posedge clk_i) disable iff (!rst_n_i)
		tx_state_q == tx_idle && tx_force_n_q && tx_test_mode_i && !tx_request_i
			|=> tx_state_q == tx_continuous_test;
	endproperty
	a_tx_continuous_test: assert property (p_tx_continuous_test) else $error("tx continuous test not entered");

	property p_read_live;
		@(posedge clk_i) disable iff (!rst_n_i)
		wb_ack_o && $past(hit0 && !wb_we_i)
			|-> wb_dat_o[3:0] == $past(tx_state_q) && wb_dat_o[6:4] == $past(rx_state);
	endproperty
	a_read_live: assert property (p_read_live) else $error("read did not return live states");

	property p_ack_once;
		@(posedge clk_i) disable iff (!rst_n_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held more than one cycle");

	////////////////////////////////////////////////////////////////////
	// Bus answer and stored fields

	// Fixed one-cycle answer; masters must still wait on ack
	property p_ack_answer;
		@(posedge clk_i) disable iff (!rst_n_i)
		bus_req && !ack_q |=> ack_q;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("bus request not answered");

	property p_req_store;
		@(posedge clk_i) disable iff (!rst_n_i)
		wr_ctrl0 |=> tx_req_q == $past(wb_dat_i[TX_CODE_LSB +: TX_W])
			&& rx_req_q == $past(wb_dat_i[RX_CODE_LSB +: RX_W]);
	endproperty
	a_req_store: assert property (p_req_store) else $error("requested codes not stored");

	property p_rx_force_store;
		@(posedge clk_i) disable iff (!rst_n_i)
		wr_ctrl0 |=> rx_force_n_q == $past(wb_dat_i[RX_FORCE_BIT]);
	endproperty
	a_rx_force_store: assert property (p_rx_force_store) else $error("rx force bit not stored");

	property p_tx_force_store;
		@(posedge clk_i) disable iff (!rst_n_i)
		wr_ctrl1 |=> tx_force_n_q == $past(wb_dat_i[TX_FORCE_BIT]);
	endproperty
	a_tx_force_store: assert property (p_tx_force_store) else $error("tx force bit not stored");

	property p_read_ctrl1;
		@(posedge clk_i) disable iff (!rst_n_i)
		wb_ack_o && $past(hit1) |-> wb_dat_o == {24'h00_0000, $past(tx_force_n_q), 7'h00};
	endproperty
	a_read_ctrl1: assert property (p_read_ctrl1) else $error("control1 read wrong");

	////////////////////////////////////////////////////////////////////
	// Holding checks

	// A reserved request must not even glitch the live state
	property p_tx_refuse;
		@(posedge clk_i) disable iff (!rst_n_i)
		!tx_force_n_q && !tx_code_legal(tx_req_q) |=> tx_state_q == $past(tx_state_q);
	endproperty
	a_tx_refuse: assert property (p_tx_refuse) else $error("tx state moved on reserved request");

	property p_tx_idle_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		tx_state_q == tx_idle && tx_force_n_q && !tx_request_i && !tx_test_mode_i
			|=> tx_state_q == tx_idle;
	endproperty
	a_tx_idle_hold: assert property (p_tx_idle_hold) else $error("tx left idle without cause");

	property p_tx_wait_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		tx_state_q == tx_fifo_wait_first && tx_force_n_q && !tx_fifo_ready_i
			|=> tx_state_q == tx_fifo_wait_first;
	endproperty
	a_tx_wait_hold: assert property (p_tx_wait_hold) else $error("tx left fifo wait early");

	property p_tx_tail_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		tx_state_q == tx_tail_send && tx_force_n_q && !tx_section_done_i
			|=> tx_state_q == tx_tail_send;
	endproperty
	a_tx_tail_hold: assert property (p_tx_tail_hold) else $error("tx tail ended early");

	property p_tx_test_stay;
		@(posedge clk_i) disable iff (!rst_n_i)
		tx_state_q == tx_continuous_test && tx_force_n_q && tx_test_mode_i
			|=> tx_state_q == tx_continuous_test;
	endproperty
	a_tx_test_stay: assert property (p_tx_test_stay) else $error("tx test mode left early");

endmodule

// File: bench/test_modem_phy_state_monitor.sv
// Self-checking bench for the modem state monitor register bank.
// Assumes a single 100 MHz clock and classic Wishbone driven from here.
module test_modem_phy_state_monitor;
	timeunit 1ns;
	timeprecision 100ps;
	import modem_phy_state_pkg::*;

	logic                clk_i;
	logic                rst_n_i;
	logic                wb_cyc_i;
	logic                wb_stb_i;
	logic                wb_we_i;
	logic [7:0]          wb_adr_i;
	logic [3:0]          wb_sel_i;
	logic [DATA_W-1:0]   wb_dat_i;
	logic [DATA_W-1:0]   wb_dat_o;
	logic                wb_ack_o;
	logic [9:0]          ev;
	tx_state_t           tx_state_o;
	rx_state_t           rx_state_o;
	int                  num_errors;
	int                  n_tests;
	logic [3:0]          legal_codes [10];

	// Event bit positions
	localparam int REQ = 0, FIFO = 1, LEN = 2, SEC = 3, CT = 4;
	localparam int EN = 5, PD = 6, TL = 7, SR = 8, SD = 9;

	modem_phy_state_monitor #(.ADDR_W(8)) u_modem_phy_state_monitor (
		.clk_i              (clk_i),
		.rst_n_i            (rst_n_i),
		.wb_cyc_i           (wb_cyc_i),
		.wb_stb_i           (wb_stb_i),
		.wb_we_i            (wb_we_i),
		.wb_adr_i           (wb_adr_i),
		.wb_sel_i           (wb_sel_i),
		.wb_dat_i           (wb_dat_i),
		.wb_dat_o           (wb_dat_o),
		.wb_ack_o           (wb_ack_o),
		.tx_request_i       (ev[REQ]),
		.tx_fifo_ready_i    (ev[FIFO]),
		.tx_length_valid_i  (ev[LEN]),
		.tx_section_done_i  (ev[SEC]),
		.tx_test_mode_i     (ev[CT]),
		.rx_enable_i        (ev[EN]),
		.rx_packet_detect_i (ev[PD]),
		.rx_timing_locked_i (ev[TL]),
		.rx_signal_ready_i  (ev[SR]),
		.rx_stage_done_i    (ev[SD]),
		.tx_state_o         (tx_state_o),
		.rx_state_o         (rx_state_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Tasks

	task automatic test_done();
		$display("Checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Waits on ack with a bound; never assumes a latency
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		if (wb_ack_o !== 1'b1) begin
			num_errors++;
			test_done();
		end
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf);
		logic [31:0] r;
		wb(1'b1, a, {24'h0, d}, s, r);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, 4'hf, r);
		check(r, {24'h0, exp});
	endtask

	task automatic st(input int n, input logic [3:0] etx, input logic [2:0] erx);
		repeat (n) @(posedge clk_i);
		#1;
		check({25'h0, rx_state_o, tx_state_o}, {25'h0, erx, etx});
	endtask

	task automatic lvl(input int b, input logic v);
		@(posedge clk_i);
		ev[b] <= v;
	endtask

	// One-cycle event, state looked at right after the sampling edge
	task automatic pulse(input int b, input logic [3:0] etx, input logic [2:0] erx);
		lvl(b, 1'b1);
		@(posedge clk_i);
		ev[b] <= 1'b0;
		#1;
		check({25'h0, rx_state_o, tx_state_o}, {25'h0, erx, etx});
	endtask

	////////////////////////////////////////////////////////////////////////
	// Clock, reset and main sequence

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	initial begin
		legal_codes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'ha};
		num_errors = 0;
		n_tests = 0;
		rst_n_i = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		ev = 10'h000;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(CTRL0_OFFS, 8'h80);
		rd(CTRL1_OFFS, 8'h80);
		// Unmapped and disabled-lane writes leave the bank untouched
		wr(8'h08, 8'h00);
		rd(8'h08, 8'h00);
		wr(CTRL1_OFFS, 8'h00, 4'he);
		rd(CTRL1_OFFS, 8'h80);
		// Transmit walk, one event at a time
		lvl(LEN, 1'b1);
		pulse(REQ, 4'h1, 3'h0);
		pulse(FIFO, 4'h2, 3'h0);
		pulse(FIFO, 4'h3, 3'h0);
		st(1, 4'h4, 3'h0);
		rd(CTRL0_OFFS, 8'h84);
		pulse(SEC, 4'h5, 3'h0);
		pulse(SEC, 4'h7, 3'h0);
		pulse(SEC, 4'h8, 3'h0);
		pulse(SEC, 4'h9, 3'h0);
		pulse(SEC, 4'h0, 3'h0);
		// Bad length drops back to idle
		lvl(LEN, 1'b0);
		pulse(REQ, 4'h1, 3'h0);
		pulse(FIFO, 4'h2, 3'h0);
		pulse(FIFO, 4'h3, 3'h0);
		st(1, 4'h0, 3'h0);
		lvl(CT, 1'b1);
		st(1, 4'ha, 3'h0);
		lvl(CT, 1'b0);
		st(1, 4'h0, 3'h0);
		// Receive walk
		lvl(EN, 1'b1);
		st(1, 4'h0, 3'h1);
		pulse(PD, 4'h0, 3'h2);
		pulse(TL, 4'h0, 3'h3);
		pulse(SR, 4'h0, 3'h4);
		pulse(SD, 4'h0, 3'h5);
		rd(CTRL0_OFFS, 8'hd0);
		pulse(SR, 4'h0, 3'h6);
		rd(CTRL0_OFFS, 8'he0);
		pulse(SD, 4'h0, 3'h7);
		st(1, 4'h0, 3'h1);
		lvl(EN, 1'b0);
		st(1, 4'h0, 3'h0);
		// Request alone must not move the modulator
		wr(CTRL0_OFFS, 8'h85);
		st(2, 4'h0, 3'h0);
		rd(CTRL0_OFFS, 8'h80);
		wr(CTRL1_OFFS, 8'h00);
		st(1, 4'h5, 3'h0);
		pulse(SEC, 4'h5, 3'h0);
		rd(CTRL1_OFFS, 8'h00);
		foreach (legal_codes[i]) begin
			wr(CTRL0_OFFS, {4'h8, legal_codes[i]});
			st(1, legal_codes[i], 3'h0);
			rd(CTRL0_OFFS, {4'h8, legal_codes[i]});
		end
		// Reserved requests are refused while forced
		wr(CTRL0_OFFS, 8'h86);
		st(1, 4'ha, 3'h0);
		for (int c = 11; c < 16; c++) begin
			wr(CTRL0_OFFS, {4'h8, c[3:0]});
			st(1, 4'ha, 3'h0);
		end
		wr(CTRL1_OFFS, 8'h80);
		st(2, 4'h0, 3'h0);
		// Receive override, events ignored while held
		lvl(EN, 1'b1);
		for (int c = 0; c < 8; c++) begin
			wr(CTRL0_OFFS, {1'b0, c[2:0], 4'h0});
			st(1, 4'h0, c[2:0]);
			pulse(PD, 4'h0, c[2:0]);
			rd(CTRL0_OFFS, {1'b0, c[2:0], 4'h0});
		end
		lvl(EN, 1'b0);
		wr(CTRL0_OFFS, 8'h80);
		st(2, 4'h0, 3'h0);
		test_done();
	end
endmodule
